// file: hdl/spi_readback_cfg.svh
// field positions, codes and reset values for the serial status readback block
`ifndef SPI_READBACK_CFG_SVH
`define SPI_READBACK_CFG_SVH

// ****************************************
// command word fields
// ****************************************
`define CMD_SIDE_BIT    7
`define CMD_ADDR_MSB    6
`define CMD_ADDR_LSB    4
`define CMD_SEL_MSB     2
`define ADDR_SELECT     3'h0
`define WORD_BITS       8

// ****************************************
// readback selector codes
// ****************************************
`define SEL_FAULT       3'h0
`define SEL_CTRL        3'h1
`define SEL_TRIP        3'h2
`define SEL_BLANK       3'h3
`define SEL_DRIVE       3'h4
`define SEL_TIMING      3'h5
`define SEL_PINS        3'h6
`define SEL_NULL        3'h7

// ****************************************
// reset values
// ****************************************
`define RST_SEL         3'h7
`define RST_SIDE        1'h0
`define RST_CNT         3'h0
// synchroniser reset levels: chip select (top bit) idles high, all else low
`define SYNC_RST_VAL    17'h10000

`endif

// file: hdl/spi_readback_pkg.sv
// types shared by the serial status readback block
package spi_readback_pkg;

  typedef enum logic {LINK_IDLE, LINK_SHIFT} link_state_type;
  typedef logic [7:0] word_type;
  typedef logic [2:0] sel_type;

endpackage : spi_readback_pkg

// file: hdl/bit_sync.sv
// two-flop synchroniser for a group of asynchronous levels
`timescale 1ns/1ps

module bit_sync #(
  parameter int               WIDTH   = 1,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  // clock and reset
  input  wire logic             clk,
  input  wire logic             rst,
  // levels
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_q;

  // the first stage feeds only the second
  always_ff @(posedge clk) begin
    if (rst) begin
      meta_q   <= RST_VAL;
      sync_out <= RST_VAL;
    end else begin
      meta_q   <= async_in;
      sync_out <= meta_q;
    end
  end

endmodule : bit_sync

// file: hdl/word_buffer.sv
// small shift-style buffer, head entry drives the output directly
`timescale 1ns/1ps

module word_buffer #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 2
) (
  // clock and reset
  input  wire logic             clk,
  input  wire logic             rst,
  // filling side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // draining side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [DEPTH:0]   cnt_q;
  logic             push;
  logic             pop;
  logic [DEPTH:0]   wr_idx;
  logic [DEPTH:0]   cnt_d;
  logic             valid_q;

  assign in_ready  = (cnt_q < (DEPTH+1)'(DEPTH));
  assign out_valid = valid_q;
  assign cnt_d     = cnt_q + (DEPTH+1)'(push) - (DEPTH+1)'(pop);
  assign out_data  = mem_q[0];
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;
  assign wr_idx    = pop ? cnt_q - 1'b1 : cnt_q;

  // entries move toward the head on a pop, so the head is always a flop
  always_ff @(posedge clk) begin
    if (rst) begin
      cnt_q   <= '0;
      valid_q <= 1'b0;
      for (int i = 0; i < DEPTH; i++) begin
        mem_q[i] <= '0;
      end
    end else begin
      for (int i = 0; i < DEPTH; i++) begin
        if (push && wr_idx == (DEPTH+1)'(i)) begin
          mem_q[i] <= in_data;
        end else if (pop && i < DEPTH-1) begin
          mem_q[i] <= mem_q[i+1];
        end
      end
      cnt_q   <= cnt_d;
      valid_q <= (cnt_d != '0);
    end
  end

endmodule : word_buffer

// file: hdl/spi_status_readback.sv
// serial slave that returns the status word and echoes the input stream
`timescale 1ns/1ps
`include "spi_readback_cfg.svh"

// Overview of operation
// - chip select low loads status, shift MSB first
// - bits after eight echo received input bits
// - latch only when bit count multiple of eight
// - chip select high releases output, ends the transfer
// - invalid transfer leaves selection and status untouched
// - returned bit seven echoes previous command bit
// - selector persists until written again
// - selector 000 returns selected switch fault flags
// - selector 001 returns sense routes, serial ons
// - selector 010 returns high and low trips
// - selector 011 returns blanking and open-load settings
// - selector 100 returns direct drive settings
// - selector 101 low returns delay, switch-zero failsafe
// - selector 101 high returns watchdog, switch-one failsafe
// - selector 110 low returns live pin levels
// - selector 110 high returns voltage guard offs
// - selector 111 returns null low bits
// - overcurrent flags latch, undervolt flag unlatched here
// - summary fault bit set by any, cleared on read
// - fail status held by latched overcurrent until new switch-on
module spi_status_readback
  import spi_readback_pkg::*;
(
  // clock and reset
  input  wire logic       CLK_SYS,
  input  wire logic       SYS_RST,
  // serial link pins
  input  wire logic       CS_N,
  input  wire logic       SCLK,
  input  wire logic       SI,
  output logic            SO_OUT,
  output logic            SO_OE,
  // device pins sampled for readback
  input  wire logic [1:0] PARALLEL_DRIVE_PIN,
  input  wire logic       FAILSAFE_STRAP_PIN,
  input  wire logic       WAKE_PIN,
  // raw fault conditions per switch
  input  wire logic [1:0] OVERTEMP,
  input  wire logic [1:0] HIGH_OVERCURRENT,
  input  wire logic [1:0] LOW_OVERCURRENT,
  input  wire logic [1:0] OPEN_LOAD,
  input  wire logic       UNDERVOLT,
  input  wire logic       OVERVOLT,
  // programmed settings, index is the switch
  input  wire logic [1:0] SENSE_ROUTE,
  input  wire logic [1:0] SERIAL_ON,
  input  wire logic [1:0] HIGH_TRIP_LEVEL,
  input  wire logic [2:0] LOW_TRIP_LEVEL_ZERO,
  input  wire logic [2:0] LOW_TRIP_LEVEL_ONE,
  input  wire logic [1:0] BLANKING_TIME_ZERO,
  input  wire logic [1:0] BLANKING_TIME_ONE,
  input  wire logic [1:0] BLANKING_TIMEOUT_OFF,
  input  wire logic [1:0] OPEN_LOAD_CHECK_OFF,
  input  wire logic [1:0] FAST_SLEW,
  input  wire logic [1:0] SENSE_HIGH_RATIO,
  input  wire logic [1:0] PARALLEL_DRIVE_OFF,
  input  wire logic [1:0] AND_OR_COMBINE,
  input  wire logic [2:0] TURN_ON_DELAY_CODE,
  input  wire logic [1:0] FAILSAFE_STATE,
  input  wire logic [1:0] WATCHDOG_PERIOD_SELECT,
  input  wire logic       WATCHDOG_EXPIRED,
  input  wire logic       UNDERVOLT_GUARD_OFF,
  input  wire logic       OVERVOLT_GUARD_OFF,
  // serial switch-on pulses, one per switch
  input  wire logic [1:0] SWITCH_ON_CMD,
  // fault pin
  output logic            FAIL_STATUS_N,
  // latched command words toward the write registers
  output logic            CMD_VALID,
  input  wire logic       CMD_READY,
  output logic [7:0]      CMD_DATA
);

  // ****************************************
  // pin synchronisation
  // ****************************************
  localparam int SYNC_W = 17;

  logic [SYNC_W-1:0] sync_raw;
  logic [SYNC_W-1:0] sync_lvl;
  logic              cs_n_s;
  logic              sclk_s;
  logic              si_s;
  logic [1:0]        par_s;
  logic              strap_s;
  logic              wake_s;
  logic [1:0]        ot_s;
  logic [1:0]        och_s;
  logic [1:0]        ocl_s;
  logic [1:0]        ol_s;
  logic              uv_s;
  logic              ov_s;

  assign sync_raw = {CS_N, SCLK, SI, PARALLEL_DRIVE_PIN, FAILSAFE_STRAP_PIN, WAKE_PIN,
                     OVERTEMP, HIGH_OVERCURRENT, LOW_OVERCURRENT, OPEN_LOAD, UNDERVOLT, OVERVOLT};
  assign {cs_n_s, sclk_s, si_s, par_s, strap_s, wake_s,
          ot_s, och_s, ocl_s, ol_s, uv_s, ov_s} = sync_lvl;

  // chip select leaves reset at its idle level, so no false select follows reset
  bit_sync #(.WIDTH(SYNC_W), .RST_VAL(`SYNC_RST_VAL)) u_sync (
    .clk      (CLK_SYS),
    .rst      (SYS_RST),
    .async_in (sync_raw),
    .sync_out (sync_lvl)
  );

  // ****************************************
  // edge detection on synchronised levels
  // ****************************************
  logic       cs_n_q;
  logic       sclk_q;
  logic [1:0] par_q;

  // reset to idle levels so no false edge follows reset
  always_ff @(posedge CLK_SYS) begin
    if (SYS_RST) begin
      cs_n_q <= 1'b1;
      sclk_q <= 1'b0;
      par_q  <= 2'h0;
    end else begin
      cs_n_q <= cs_n_s;
      sclk_q <= sclk_s;
      par_q  <= par_s;
    end
  end

  wire       cs_fall   = cs_n_q & ~cs_n_s;
  wire       cs_rise   = ~cs_n_q & cs_n_s;
  wire       sclk_rise = ~sclk_q & sclk_s & ~cs_n_s;
  wire       sclk_fall = sclk_q & ~sclk_s & ~cs_n_s;
  wire [1:0] par_rise  = ~par_q & par_s;

  // ****************************************
  // transfer state and shift paths
  // ****************************************
  link_state_type state_q;
  word_type       sh_q;
  word_type       rx_q;
  logic           si_cap_q;
  logic [2:0]     cnt_q;
  logic           seen_q;
  logic           so_oe_q;
  word_type       status_word;
  logic           buf_ready;
  logic           read_fault_q;

  // a word counts only with a whole number of bytes and room in the buffer
  wire xfer_valid = seen_q & (cnt_q == `RST_CNT) & buf_ready;
  wire xfer_done  = cs_rise & (state_q == LINK_SHIFT);
  wire latch_word = xfer_done & xfer_valid;

  // link state follows chip select
  always_ff @(posedge CLK_SYS) begin
    if (SYS_RST) begin
      state_q <= LINK_IDLE;
      so_oe_q <= 1'b0;
    end else if (cs_fall) begin
      state_q <= LINK_SHIFT;
      so_oe_q <= 1'b1;
    end else if (cs_rise) begin
      state_q <= LINK_IDLE;
      so_oe_q <= 1'b0;
    end
  end

  // input is taken on the rising clock edge, output moves on the falling one
  always_ff @(posedge CLK_SYS) begin
    if (SYS_RST) begin
      sh_q     <= '0;
      rx_q     <= '0;
      si_cap_q <= 1'b0;
      cnt_q    <= `RST_CNT;
      seen_q   <= 1'b0;
    end else if (cs_fall) begin
      sh_q   <= status_word;
      cnt_q  <= `RST_CNT;
      seen_q <= 1'b0;
    end else if (sclk_rise) begin
      si_cap_q <= si_s;
      rx_q     <= {rx_q[6:0], si_s};
      cnt_q    <= cnt_q + 3'h1;
      seen_q   <= 1'b1;
    end else if (sclk_fall) begin
      sh_q <= {sh_q[6:0], si_cap_q};
    end
  end

  assign SO_OUT = sh_q[7];
  assign SO_OE  = so_oe_q;

  // ****************************************
  // selector and side memory
  // ****************************************
  sel_type sel_q;
  logic    side_q;

  // only a valid word may change them; the last byte in is ours
  always_ff @(posedge CLK_SYS) begin
    if (SYS_RST) begin
      sel_q  <= `RST_SEL;
      side_q <= `RST_SIDE;
    end else if (latch_word) begin
      side_q <= rx_q[`CMD_SIDE_BIT];
      if (rx_q[`CMD_ADDR_MSB:`CMD_ADDR_LSB] == `ADDR_SELECT) begin
        sel_q <= rx_q[`CMD_SEL_MSB:0];
      end
    end
  end

  // ****************************************
  // fault capture
  // ****************************************
  logic [1:0] och_q;
  logic [1:0] ocl_q;
  logic       fault_sum_q;
  logic       fail_n_q;

  wire [1:0] switch_on  = SWITCH_ON_CMD | par_rise;
  wire       uv_rep     = uv_s & ~UNDERVOLT_GUARD_OFF;
  wire       ov_rep     = ov_s & ~OVERVOLT_GUARD_OFF;
  wire       live_fault = (|ot_s) | (|och_s) | (|ocl_s) | (|ol_s) | uv_rep | ov_rep;
  wire       read_clear = latch_word & read_fault_q;

  // overcurrent flags stick until a new switch-on; a new event wins the tie
  always_ff @(posedge CLK_SYS) begin
    if (SYS_RST) begin
      och_q <= 2'h0;
      ocl_q <= 2'h0;
    end else begin
      och_q <= och_s | (och_q & ~switch_on);
      ocl_q <= ocl_s | (ocl_q & ~switch_on);
    end
  end

  // summary bit cleared once a valid transfer has returned it
  always_ff @(posedge CLK_SYS) begin
    if (SYS_RST) begin
      fault_sum_q  <= 1'b0;
      read_fault_q <= 1'b0;
      fail_n_q     <= 1'b1;
    end else begin
      fault_sum_q <= live_fault | (fault_sum_q & ~read_clear);
      if (cs_fall) begin
        read_fault_q <= (sel_q == `SEL_FAULT);
      end
      fail_n_q <= ~(live_fault | (|och_q) | (|ocl_q));
    end
  end

  assign FAIL_STATUS_N = fail_n_q;

  // ****************************************
  // status word selection
  // ****************************************
  word_type words [8];
  wire      s = side_q;

  assign words[0] = {s, ot_s[s], och_q[s], ocl_q[s], ol_s[s], uv_rep, ov_rep, fault_sum_q};
  assign words[1] = {s, `SEL_CTRL, SENSE_ROUTE[1], SERIAL_ON[1], SENSE_ROUTE[0], SERIAL_ON[0]};
  assign words[2] = {s, `SEL_TRIP, HIGH_TRIP_LEVEL[s],
                     s ? LOW_TRIP_LEVEL_ONE : LOW_TRIP_LEVEL_ZERO};
  assign words[3] = {s, `SEL_BLANK, OPEN_LOAD_CHECK_OFF[s], BLANKING_TIMEOUT_OFF[s],
                     s ? BLANKING_TIME_ONE : BLANKING_TIME_ZERO};
  assign words[4] = {s, `SEL_DRIVE, FAST_SLEW[s], SENSE_HIGH_RATIO[s],
                     PARALLEL_DRIVE_OFF[s], AND_OR_COMBINE[s]};
  assign words[5] = s ? {s, `SEL_TIMING, FAILSAFE_STATE[1], WATCHDOG_EXPIRED, WATCHDOG_PERIOD_SELECT}
                      : {s, `SEL_TIMING, FAILSAFE_STATE[0], TURN_ON_DELAY_CODE};
  assign words[6] = s ? {s, `SEL_PINS, 2'h0, UNDERVOLT_GUARD_OFF, OVERVOLT_GUARD_OFF}
                      : {s, `SEL_PINS, par_s[1], par_s[0], strap_s, wake_s};
  assign words[7] = {s, `SEL_NULL, 4'h0};
  assign status_word = words[sel_q];

  // ****************************************
  // command word buffer
  // ****************************************
  // a word arriving with the buffer full is refused like a short one,
  // because the serial master cannot be held off mid-frame
  word_buffer #(.WIDTH(`WORD_BITS), .DEPTH(2)) u_buf (
    .clk       (CLK_SYS),
    .rst       (SYS_RST),
    .in_valid  (latch_word),
    .in_ready  (buf_ready),
    .in_data   (rx_q),
    .out_valid (CMD_VALID),
    .out_ready (CMD_READY),
    .out_data  (CMD_DATA)
  );

  // ****************************************
  // assertions
  // ****************************************
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (SYS_RST);

  AST_LOAD_STATUS: assert property (cs_fall |=> sh_q == $past(status_word))
    else $error("status word not loaded at select");
  AST_ECHO_INPUT: assert property (sclk_fall && !cs_fall |=> sh_q[0] == $past(si_cap_q))
    else $error("echoed bit differs from captured input");
  AST_WHOLE_BYTES: assert property (latch_word |-> cnt_q == 3'h0 && seen_q)
    else $error("word latched with partial byte");
  AST_RELEASE_SO: assert property (cs_rise |=> !SO_OE ##1 !SO_OE)
    else $error("output still driven after deselect");
  AST_INVALID_KEEP: assert property (xfer_done && !xfer_valid |=> $stable(sel_q) && $stable(side_q))
    else $error("invalid transfer changed selection");
  AST_SIDE_BIT: assert property (latch_word |=> side_q == $past(rx_q[7]))
    else $error("side bit not taken from command");
  AST_SEL_PERSIST: assert property (!latch_word |=> $stable(sel_q))
    else $error("selector changed without a write");
  AST_CTRL_ECHO: assert property (sel_q == `SEL_CTRL |-> status_word[6:4] == 3'h1)
    else $error("control word echo wrong");
  AST_NULL_LOW: assert property (sel_q == `SEL_NULL |-> status_word[2:0] == 3'h0)
    else $error("null word not zero");
  AST_OC_LATCHED: assert property (och_q[0] && !switch_on[0] |=> och_q[0])
    else $error("overcurrent flag dropped");
  AST_SUM_SET: assert property (live_fault |=> fault_sum_q)
    else $error("summary fault not set");
  AST_FAIL_PIN: assert property ((|och_q) || (|ocl_q) |=> !FAIL_STATUS_N)
    else $error("fail pin not reporting latched fault");
  AST_SIDE_OUT: assert property (cs_fall |=> SO_OUT == $past(side_q))
    else $error("first bit out is not the side bit");
  AST_CMD_ENTERS: assert property (latch_word |=> CMD_VALID)
    else $error("latched word missing from buffer");
  AST_OC_CLEAR: assert property (switch_on[0] && !och_s[0] |=> !och_q[0])
    else $error("overcurrent flag kept after switch-on");
  AST_SUM_CLEAR: assert property (read_clear && !live_fault |=> !fault_sum_q)
    else $error("summary fault kept after read");

  COV_VALID_BYTE: cover property (latch_word && rx_q[6:4] == `ADDR_SELECT);
  COV_INVALID: cover property (xfer_done && seen_q && cnt_q != 3'h0);
  COV_FAULT_READ: cover property (read_clear);
  COV_BUF_FULL: cover property (xfer_done && !buf_ready);
  COV_SIDE_ONE: cover property (cs_fall && side_q && sel_q == `SEL_TIMING);

endmodule : spi_status_readback

// file: verif/spi_host_model.sv
// serial bus master model standing in for the host controller
`timescale 1ns/1ps

module spi_host_model (
  // clock
  input  wire logic        clk,
  // serial link
  output logic             cs_n,
  output logic             sclk,
  output logic             si,
  input  wire logic        so_out,
  input  wire logic        so_oe,
  // reply of the last frame
  output logic [15:0]      rx_word,
  output logic             rx_stb
);
  initial begin
    cs_n = 1'b1;
    sclk = 1'b0;
    si = 1'b0;
    rx_word = '0;
    rx_stb = 1'b0;
  end

  // data line between frames keeps moving, so no stale level can pass for data
  always @(negedge clk) begin
    if (cs_n)
      si = ~si;
  end

  // ****************************************
  // one frame of n bits, d sent from bit 15 down; sclk idles low, 400 ns a phase
  // ****************************************
  task automatic xfer(input int n, input logic [15:0] d);
    logic [15:0] r;
    r = '0;
    @(negedge clk);
    cs_n = 1'b0;
    repeat (5) @(negedge clk);
    for (int i = 0; i < n; i++) begin
      si = d[15-i];
      repeat (4) @(negedge clk);
      r = {r[14:0], (so_oe === 1'b1) ? so_out : ~so_out}; // a released line shows the inverse level
      sclk = 1'b1;
      repeat (4) @(negedge clk);
      sclk = 1'b0;
    end
    repeat (4) @(negedge clk);
    cs_n = 1'b1;
    repeat (6) @(negedge clk);
    rx_word = r;
    rx_stb = 1'b1;
    @(negedge clk);
    rx_stb = 1'b0;
  endtask : xfer
endmodule : spi_host_model

// file: verif/spi_status_readback_tb.sv
// self-checking bench for the serial status readback block
`timescale 1ns/1ps

module spi_status_readback_tb
  import spi_readback_pkg::*;
;
  logic CLK_SYS, SYS_RST, CMD_READY, CMD_VALID, SO_OUT, SO_OE, FAIL_STATUS_N, FAILSAFE_STRAP_PIN, WAKE_PIN;
  logic UNDERVOLT, OVERVOLT, WATCHDOG_EXPIRED, UNDERVOLT_GUARD_OFF, OVERVOLT_GUARD_OFF, CS_N, SCLK, SI, rx_stb;
  logic [1:0] PARALLEL_DRIVE_PIN, OVERTEMP, HIGH_OVERCURRENT, LOW_OVERCURRENT, OPEN_LOAD, SENSE_ROUTE, SERIAL_ON;
  logic [1:0] HIGH_TRIP_LEVEL, BLANKING_TIME_ZERO, BLANKING_TIME_ONE, BLANKING_TIMEOUT_OFF, OPEN_LOAD_CHECK_OFF;
  logic [1:0] FAST_SLEW, SENSE_HIGH_RATIO, PARALLEL_DRIVE_OFF, AND_OR_COMBINE, FAILSAFE_STATE;
  logic [1:0] WATCHDOG_PERIOD_SELECT, SWITCH_ON_CMD;
  logic [2:0] LOW_TRIP_LEVEL_ZERO, LOW_TRIP_LEVEL_ONE, TURN_ON_DELAY_CODE, cur_sel;
  word_type   CMD_DATA;
  word_type   exp_cmd[$];
  logic [15:0] rx_word;
  logic [16:0] exp_so[$];     // top bit: reply is to be compared
  logic       cur_side;
  int         error_cnt, n_compared, bufn;
  int         lens[5] = '{16, 7, 9, 0, 15};

  spi_status_readback DUT (.CLK_SYS, .SYS_RST, .CS_N, .SCLK, .SI, .SO_OUT, .SO_OE, .PARALLEL_DRIVE_PIN,
    .FAILSAFE_STRAP_PIN, .WAKE_PIN, .OVERTEMP, .HIGH_OVERCURRENT, .LOW_OVERCURRENT, .OPEN_LOAD, .UNDERVOLT,
    .OVERVOLT, .SENSE_ROUTE, .SERIAL_ON, .HIGH_TRIP_LEVEL, .LOW_TRIP_LEVEL_ZERO, .LOW_TRIP_LEVEL_ONE,
    .BLANKING_TIME_ZERO, .BLANKING_TIME_ONE, .BLANKING_TIMEOUT_OFF, .OPEN_LOAD_CHECK_OFF, .FAST_SLEW,
    .SENSE_HIGH_RATIO, .PARALLEL_DRIVE_OFF, .AND_OR_COMBINE, .TURN_ON_DELAY_CODE, .FAILSAFE_STATE,
    .WATCHDOG_PERIOD_SELECT, .WATCHDOG_EXPIRED, .UNDERVOLT_GUARD_OFF, .OVERVOLT_GUARD_OFF, .SWITCH_ON_CMD,
    .FAIL_STATUS_N, .CMD_VALID, .CMD_READY, .CMD_DATA);

  spi_host_model HOST (.clk(CLK_SYS), .cs_n(CS_N), .sclk(SCLK), .si(SI), .so_out(SO_OUT), .so_oe(SO_OE),
    .rx_word(rx_word), .rx_stb(rx_stb));

  initial begin
    CLK_SYS = 1'b0;
    forever #50 CLK_SYS = ~CLK_SYS;
  end

  // ****************************************
  // comparison, expected words, stimulus
  // ****************************************
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      error_cnt++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // status word of selector k for side s, fault inputs quiet
  function automatic word_type exp_word(input logic [2:0] k, input logic s);
    case (k)
      3'h0: return {s, 7'h00};
      3'h1: return {s, 3'h1, SENSE_ROUTE[1], SERIAL_ON[1], SENSE_ROUTE[0], SERIAL_ON[0]};
      3'h2: return {s, 3'h2, HIGH_TRIP_LEVEL[s], s ? LOW_TRIP_LEVEL_ONE : LOW_TRIP_LEVEL_ZERO};
      3'h3: return {s, 3'h3, OPEN_LOAD_CHECK_OFF[s], BLANKING_TIMEOUT_OFF[s],
                    s ? BLANKING_TIME_ONE : BLANKING_TIME_ZERO};
      3'h4: return {s, 3'h4, FAST_SLEW[s], SENSE_HIGH_RATIO[s], PARALLEL_DRIVE_OFF[s], AND_OR_COMBINE[s]};
      3'h5: return s ? {4'hD, FAILSAFE_STATE[1], WATCHDOG_EXPIRED, WATCHDOG_PERIOD_SELECT}
                     : {4'h5, FAILSAFE_STATE[0], TURN_ON_DELAY_CODE};
      3'h6: return s ? {6'h38, UNDERVOLT_GUARD_OFF, OVERVOLT_GUARD_OFF}
                     : {4'h6, PARALLEL_DRIVE_PIN, FAILSAFE_STRAP_PIN, WAKE_PIN};
      default: return {s, 7'h70};
    endcase
  endfunction : exp_word

  // new random settings and pin levels, then time for the synchronisers
  task automatic shake;
    logic [63:0] r;
    r = {$urandom, $urandom};
    {SENSE_ROUTE, SERIAL_ON, HIGH_TRIP_LEVEL, BLANKING_TIMEOUT_OFF, OPEN_LOAD_CHECK_OFF, FAST_SLEW, SENSE_HIGH_RATIO,
     PARALLEL_DRIVE_OFF, AND_OR_COMBINE, FAILSAFE_STATE, LOW_TRIP_LEVEL_ZERO, LOW_TRIP_LEVEL_ONE, BLANKING_TIME_ZERO,
     BLANKING_TIME_ONE, TURN_ON_DELAY_CODE, WATCHDOG_PERIOD_SELECT, WATCHDOG_EXPIRED, UNDERVOLT_GUARD_OFF,
     OVERVOLT_GUARD_OFF, PARALLEL_DRIVE_PIN, FAILSAFE_STRAP_PIN, WAKE_PIN} = r[41:0];
    repeat (4) @(negedge CLK_SYS);
  endtask : shake

  // one frame; ov -1 predicts the word, -2 discards the reply, else gives it
  task automatic frame(input int n, input logic [15:0] d, input int ov = -1);
    word_type w;
    logic [23:0] s;
    w = (ov < 0) ? exp_word(cur_sel, cur_side) : ov[7:0];
    s = {w, d} >> (24 - n);
    exp_so.push_back({ov != -2, s[15:0]});
    // command note goes in first: the word may leave the buffer before the frame task returns
    if (n > 0 && n % 8 == 0 && bufn < 2) begin
      s = {8'h00, d} >> (16 - n);
      w = s[7:0];
      exp_cmd.push_back(w);
      bufn++;
      cur_side = w[7];
      if (w[6:4] == 3'h0)
        cur_sel = w[2:0];
    end
    HOST.xfer(n, d);
    check({15'h0, SO_OE}, 16'h0);
  endtask : frame

  task automatic print_verdict;
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : print_verdict

  // ****************************************
  // result watchers: oldest note against each reply
  // ****************************************
  always @(posedge rx_stb) begin : so_watch
    logic [16:0] e;
    e = exp_so.pop_front();
    if (e[16])
      check(rx_word, e[15:0]);
  end

  always @(posedge CLK_SYS) begin
    if (CMD_VALID === 1'b1 && CMD_READY) begin
      if (exp_cmd.size() == 0)
        check({8'h00, CMD_DATA}, 16'hFFFF);
      else
        check({8'h00, CMD_DATA}, {8'h00, exp_cmd.pop_front()});
      bufn--;
    end
  end

  initial begin
    #3_000_000;
    error_cnt++;
    print_verdict();
  end

  initial begin
    void'($urandom(32'h8CF889C7));
    {OVERTEMP, HIGH_OVERCURRENT, LOW_OVERCURRENT, OPEN_LOAD, UNDERVOLT, OVERVOLT, SWITCH_ON_CMD} = '0;
    CMD_READY = 1'b1;
    SYS_RST = 1'b1;
    error_cnt = 0;
    n_compared = 0;
    bufn = 0;
    cur_sel = 3'h7;
    cur_side = 1'b0;
    shake();
    repeat (2) @(negedge CLK_SYS);
    SYS_RST = 1'b0;
    repeat (3) @(negedge CLK_SYS);
    frame(8, 16'h0100);
    $display("test null_after_reset done");
    // every selector on both sides; the third frame shows the choice persists
    for (int s = 0; s < 2; s++) begin
      for (int k = 0; k < 8; k++) begin
        frame(8, {s[0], 4'h0, k[2:0], 8'h00});
        shake();
        frame(8, {s[0], 3'($urandom_range(7, 1)), 4'($urandom), 8'h00});
        frame(8, {s[0], 3'h1, 4'h0, 8'h00});
      end
    end
    $display("test selector_map done");
    // long frames echo, odd lengths change nothing
    shake();
    foreach (lens[i])
      frame(lens[i], 16'($urandom));
    $display("test length_and_echo done");
    // receiver stalls: third byte meets a full buffer and is dropped
    CMD_READY = 1'b0;
    for (int i = 0; i < 3; i++)
      frame(8, {1'b1, 4'h0, 3'(i + 2), 8'h00});
    CMD_READY = 1'b1;
    repeat (4) @(negedge CLK_SYS);
    frame(8, 16'h0000);
    $display("test buffer_full done");
    // latched overcurrent, summary cleared by reading, pin freed by switch-on
    HIGH_OVERCURRENT = 2'b01;
    repeat (4) @(negedge CLK_SYS);
    HIGH_OVERCURRENT = 2'b00;
    repeat (8) @(negedge CLK_SYS);
    check({15'h0, FAIL_STATUS_N}, 16'h0);
    frame(8, 16'h0000, 8'h21);
    SWITCH_ON_CMD = 2'b01;
    @(negedge CLK_SYS);
    SWITCH_ON_CMD = 2'b00;
    repeat (8) @(negedge CLK_SYS);
    check({15'h0, FAIL_STATUS_N}, 16'h1);
    frame(8, 16'h0000, -2);
    frame(8, 16'h0000);
    $display("test fault_word done");
    repeat (10) @(negedge CLK_SYS);
    check(16'(exp_cmd.size()), 16'h0);
    print_verdict();
  end
endmodule : spi_status_readback_tb
